// File: display_store.sv
// Display storage: serial shift register and display latch
`timescale 1ns/100ps
`default_nettype none
module display_store #(
    parameter int WIDTH = seglcd_pkg::NUM_STAGE
) (
    input wire logic clk, // System clock
    input wire logic srst, // Synchronous reset
    input wire logic shift_en, // One-cycle shift request
    input wire logic bit_in, // Serial bit entering stage 1
    input wire logic load_en, // Latch transparent while high
    output logic [WIDTH-1:0] shift_q, // Shift register, bit 0 is stage 1
    output logic [WIDTH-1:0] latch_q // Display latch contents
);
    typedef struct packed {
        logic [WIDTH-1:0] sreg;
        logic [WIDTH-1:0] latch;
    } store_type;

    store_type st_ff;
    store_type nxt_st;

    // ==========================================================
    // Next state
    always_comb begin
        nxt_st = st_ff;
        if (shift_en) begin
            nxt_st.sreg = {st_ff.sreg[WIDTH-2:0], bit_in};
        end
        if (load_en) begin
            nxt_st.latch = st_ff.sreg;
        end
    end

    // Register
    always_ff @(posedge clk) begin
        if (srst) begin
            st_ff <= '0;
        end else begin
            st_ff <= nxt_st;
        end
    end

    assign shift_q = st_ff.sreg;
    assign latch_q = st_ff.latch;
endmodule // display_store
`default_nettype wire

// File: host_link.sv
// Host model: drives shift clock, serial data and load strobe
`timescale 1ns/100ps
`default_nettype none
module host_link (
    input wire logic clk, // System clock
    output logic data_o, // Serial data
    output logic shclk_o, // Shift clock, still between frames
    output logic load_o // Load strobe
);
    // ==========================================
    // Idle levels
    initial begin
        data_o = 1'h0;
        shclk_o = 1'h0;
        load_o = 1'h0;
    end
    // Oldest bit first; 400 ns shift period, data moves with the falling edge
    task automatic send(input logic [159:0] bits, input int n, input logic ld);
        for (int i = n - 1; i >= 0; i--) begin
            data_o <= bits[i];
            shclk_o <= 1'h0;
            repeat (4) @(posedge clk);
            shclk_o <= 1'h1;
            repeat (4) @(posedge clk);
        end
        shclk_o <= 1'h0;
        data_o <= ~bits[0]; // Released line shows inverted level
        repeat (4) @(posedge clk);
        load_o <= ld;
        repeat (4) @(posedge clk);
        load_o <= 1'h0;
        repeat (4) @(posedge clk);
    endtask
endmodule // host_link
`default_nettype wire

// File: seglcd_driver.sv
// Serial segment LCD driver with common generation and AXI4-Lite status
`timescale 1ns/100ps
`default_nettype none
// Operation
// - Eighty segment outputs; eighty segments static, one hundred sixty in half duty.
// - Stored one turns a segment on, zero turns it off.
// - Serial bit enters the shift register on each shift clock rising edge.
// - Latch follows the shift register while load is high, holds when low.
// - Blanking turns all segments off; level set per variant; release restores.
// - Test input forces all segments on and overrides blanking.
// - Mode select high gives half duty dynamic, low gives static.
// - Common select high uses oscillator input as common, buffered to common output.
// - Expander: select high, oscillator input low; oscillator high inverts outputs.
// - Cascaded dynamic devices share a pulled-up line aligning common phases.
// - Stage eighty appears on the static cascade output.
// - Stage one hundred sixty appears on the dynamic cascade output.
// - Static commons follow common output; dynamic commons alternate select each common half period.
module seglcd_driver #(
    parameter int COM_HALF_CYCLES = seglcd_pkg::COM_HALF_CYC,
    parameter logic BLANK_ACTIVE_HIGH = seglcd_pkg::BLANK_ACTIVE_HIGH
) (
    input wire logic CLK, // System clock, 20 MHz
    input wire logic SRST, // Synchronous reset, active high
    input wire logic SERIAL_DATA_IN, // Serial display data
    input wire logic SHIFT_CLK, // Shift clock from host
    input wire logic LOAD_STROBE, // Latch load, level sensitive
    input wire logic BLANK_IN, // All-off input, polarity by parameter
    input wire logic ALL_ON_TEST_INPUT, // All-on test, high active
    input wire logic DYNAMIC_MODE_SELECT, // High: half duty, low: static
    input wire logic COMMON_SOURCE_SELECT, // High: external common
    input wire logic OSC_COMMON_INPUT, // External common or expander polarity
    output logic OSC_DRIVE_OUTPUT, // Built-in common generator output
    input wire logic PHASE_ALIGN_I, // Shared alignment line level
    output logic PHASE_ALIGN_O, // Alignment line drive value
    output logic PHASE_ALIGN_OE, // High while pulling the line low
    output logic CASCADE_OUT_STATIC, // Shift stage 80
    output logic CASCADE_OUT_DYNAMIC, // Shift stage 160
    output logic COMMON_PHASE_OUTPUT, // Buffered common signal
    output logic LCD_COMMON_FIRST, // First common level
    output logic LCD_COMMON_FIRST_MID, // First common at non-select bias
    output logic LCD_COMMON_SECOND, // Second common level
    output logic LCD_COMMON_SECOND_MID, // Second common at non-select bias
    output logic [seglcd_pkg::NUM_SEG-1:0] SEGMENT_OUTPUTS, // Segment levels
    input wire logic [seglcd_pkg::ADDR_W-1:0] AWADDR, // Write address
    input wire logic AWVALID, // Write address valid
    output logic AWREADY, // Write address ready
    input wire logic [31:0] WDATA, // Write data
    input wire logic [3:0] WSTRB, // Write byte strobes
    input wire logic WVALID, // Write data valid
    output logic WREADY, // Write data ready
    output logic [1:0] BRESP, // Write response
    output logic BVALID, // Write response valid
    input wire logic BREADY, // Write response ready
    input wire logic [seglcd_pkg::ADDR_W-1:0] ARADDR, // Read address
    input wire logic ARVALID, // Read address valid
    output logic ARREADY, // Read address ready
    output logic [31:0] RDATA, // Read data
    output logic [1:0] RRESP, // Read response
    output logic RVALID, // Read data valid
    input wire logic RREADY // Read data ready
);
    // Widths and short names
    localparam int CNT_W = $clog2(COM_HALF_CYCLES + 1);
    localparam int NSEG = seglcd_pkg::NUM_SEG;
    localparam int NSTG = seglcd_pkg::NUM_STAGE;
    localparam int AW = seglcd_pkg::ADDR_W;

    // Driver state apart from the shift chain and latch
    typedef struct packed {
        seglcd_pkg::pin_type meta;
        seglcd_pkg::pin_type pins;
        logic shclk_d;
        logic [CNT_W-1:0] div_cnt;
        logic int_com;
        logic com_d;
        seglcd_pkg::phase_type ph;
        logic align_oe;
        logic [NSEG-1:0] seg;
        logic com_first;
        logic com_second;
        logic first_mid;
        logic second_mid;
        logic common_phase_output;
        logic soft_blank;
        logic aw_got;
        logic [AW-1:0] aw_addr;
        logic w_got;
        logic [31:0] w_data;
        logic [3:0] w_strb;
        logic bvalid;
        logic [1:0] bresp;
        logic rvalid;
        logic [31:0] rdata;
        logic [1:0] rresp;
    } state_type;

    // State and helpers
    state_type st_ff;
    state_type nxt_st;
    seglcd_pkg::pin_type pin_raw;
    logic [NSTG-1:0] shift_q;
    logic [NSTG-1:0] latch_q;
    logic shift_en;

    // ==========================================================
    // Address decoding shared by reads and writes
    function automatic logic addr_hit(input logic [AW-1:0] a);
        logic in_latch;
        // Aligned word inside the latch block
        in_latch = (a >= seglcd_pkg::REG_LATCH0) &&
            (a < seglcd_pkg::REG_LATCH0 + AW'(4 * seglcd_pkg::LATCH_WORDS)) &&
            (a[1:0] == 2'h0);
        addr_hit = (a == seglcd_pkg::REG_CTRL) ||
            (a == seglcd_pkg::REG_STATUS) ||
            in_latch;
    endfunction

    // Read data for one mapped word
    function automatic logic [31:0] read_word(input logic [AW-1:0] a, input state_type s,
        input logic [NSTG-1:0] lat);
        logic [AW-1:0] off;
        logic [31:0] w;
        // Offset into latch
        off = a - seglcd_pkg::REG_LATCH0;
        w = 32'h00000000;
        if (a == seglcd_pkg::REG_CTRL) begin
            w[seglcd_pkg::CTRL_SOFT_BLANK] = s.soft_blank;
        end else if (a == seglcd_pkg::REG_STATUS) begin
            // Live pins and state
            w[seglcd_pkg::ST_DYN] = s.pins.dyn;
            w[seglcd_pkg::ST_CSEL] = s.pins.csel;
            w[seglcd_pkg::ST_COM] = s.common_phase_output;
            w[seglcd_pkg::ST_PHASE] = s.ph;
            w[seglcd_pkg::ST_ALIGN] = s.pins.align;
            w[seglcd_pkg::ST_BLANK] = (s.pins.blank == BLANK_ACTIVE_HIGH) | s.soft_blank;
            w[seglcd_pkg::ST_TEST] = s.pins.test;
            w[seglcd_pkg::ST_LOAD] = s.pins.load;
        end else begin
            // Latch word
            w = lat[int'(off[AW-1:2]) * seglcd_pkg::WORD_W +: seglcd_pkg::WORD_W];
        end
        read_word = w;
    endfunction

    // ==========================================================
    // Pin gathering and storage
    always_comb begin
        pin_raw.data = SERIAL_DATA_IN;
        pin_raw.shclk = SHIFT_CLK;
        pin_raw.load = LOAD_STROBE;
        pin_raw.blank = BLANK_IN;
        pin_raw.test = ALL_ON_TEST_INPUT;
        pin_raw.dyn = DYNAMIC_MODE_SELECT;
        pin_raw.csel = COMMON_SOURCE_SELECT;
        pin_raw.osc = OSC_COMMON_INPUT;
        pin_raw.align = PHASE_ALIGN_I;
    end

    // Rising edge of the synchronised shift clock
    assign shift_en = st_ff.pins.shclk & ~st_ff.shclk_d;

    // Shift chain and latch
    display_store #(
        .WIDTH(NSTG)
    ) u_store (
        .clk(CLK),
        .srst(SRST),
        .shift_en(shift_en),
        .bit_in(st_ff.pins.data),
        .load_en(st_ff.pins.load),
        .shift_q(shift_q),
        .latch_q(latch_q)
    );

    // ==========================================================
    // Next state
    always_comb begin
        // Scratch values
        logic com;
        logic rise;
        logic fall;
        logic blank_now;
        logic [NSEG-1:0] half;
        logic [NSEG-1:0] on;
        com = 1'b0;
        rise = 1'b0;
        fall = 1'b0;
        blank_now = 1'b0;
        half = '0;
        on = '0;
        // Hold by default
        nxt_st = st_ff;

        // Two flip-flops on every pin
        nxt_st.meta = pin_raw;
        nxt_st.pins = st_ff.meta;
        nxt_st.shclk_d = st_ff.pins.shclk;

        // Built-in common generator
        if (st_ff.div_cnt == CNT_W'(COM_HALF_CYCLES - 1)) begin
            // Wrap per half period
            nxt_st.div_cnt = '0;
            nxt_st.int_com = ~st_ff.int_com;
        end else begin
            nxt_st.div_cnt = st_ff.div_cnt + CNT_W'(1);
        end

        // Common source choice
        com = st_ff.pins.csel ? st_ff.pins.osc : st_ff.int_com;
        nxt_st.com_d = com;
        nxt_st.common_phase_output = com;
        rise = com & ~st_ff.com_d;
        fall = ~com & st_ff.com_d;

        // Phase of the two commons, aligned over the shared line
        if (!st_ff.pins.dyn) begin
            nxt_st.ph = seglcd_pkg::PH_FIRST;
        end else if (rise) begin
            nxt_st.ph = seglcd_pkg::PH_FIRST;
        end else if (fall && st_ff.ph == seglcd_pkg::PH_FIRST && st_ff.pins.align) begin
            nxt_st.ph = seglcd_pkg::PH_SECOND;
        end
        // Hold the line low while in the second phase
        nxt_st.align_oe = st_ff.pins.dyn && (st_ff.ph == seglcd_pkg::PH_SECOND);

        // Common outputs
        nxt_st.com_first = com;
        nxt_st.com_second = com;
        nxt_st.first_mid = st_ff.pins.dyn && (st_ff.ph == seglcd_pkg::PH_SECOND);
        nxt_st.second_mid = st_ff.pins.dyn && (st_ff.ph == seglcd_pkg::PH_FIRST);

        // Pick the latch half that the selected common serves
        if (st_ff.pins.dyn && st_ff.ph == seglcd_pkg::PH_SECOND) begin
            half = latch_q[NSTG-1:NSEG];
        end else begin
            half = latch_q[NSEG-1:0];
        end

        // Test overrides blanking, blanking overrides data
        blank_now = (st_ff.pins.blank == BLANK_ACTIVE_HIGH) | st_ff.soft_blank;
        if (st_ff.pins.test) begin
            on = '1;
        end else if (blank_now) begin
            on = '0;
        end else begin
            on = half;
        end
        // Segment on drives the common complement
        nxt_st.seg = {NSEG{com}} ^ on;

        // Write address and data, taken in either order
        if (AWVALID && !st_ff.aw_got && !st_ff.bvalid) begin
            nxt_st.aw_got = 1'b1;
            nxt_st.aw_addr = AWADDR;
        end
        if (WVALID && !st_ff.w_got && !st_ff.bvalid) begin
            nxt_st.w_got = 1'b1;
            nxt_st.w_data = WDATA;
            nxt_st.w_strb = WSTRB;
        end
        // Perform write once both halves are held
        if (st_ff.aw_got && st_ff.w_got && !st_ff.bvalid) begin
            nxt_st.aw_got = 1'b0;
            nxt_st.w_got = 1'b0;
            nxt_st.bvalid = 1'b1;
            // Only control keeps data
            if (addr_hit(st_ff.aw_addr)) begin
                nxt_st.bresp = seglcd_pkg::RESP_OKAY;
                if (st_ff.aw_addr == seglcd_pkg::REG_CTRL && st_ff.w_strb[0]) begin
                    nxt_st.soft_blank = st_ff.w_data[seglcd_pkg::CTRL_SOFT_BLANK];
                end
            end else begin
                nxt_st.bresp = seglcd_pkg::RESP_SLVERR;
            end
        end else if (st_ff.bvalid && BREADY) begin
            // Response taken
            nxt_st.bvalid = 1'b0;
        end

        // Read channel, one read in flight
        if (st_ff.rvalid) begin
            if (RREADY) begin
                nxt_st.rvalid = 1'b0;
            end
        end else if (ARVALID) begin
            nxt_st.rvalid = 1'b1;
            // Unmapped: error, zero
            if (addr_hit(ARADDR)) begin
                nxt_st.rdata = read_word(ARADDR, st_ff, latch_q);
                nxt_st.rresp = seglcd_pkg::RESP_OKAY;
            end else begin
                nxt_st.rdata = 32'h00000000;
                nxt_st.rresp = seglcd_pkg::RESP_SLVERR;
            end
        end
    end

    // ==========================================================
    // Register
    always_ff @(posedge CLK) begin
        if (SRST) begin
            st_ff <= '0;
            // Own reset value
            st_ff.soft_blank <= seglcd_pkg::SOFT_BLANK_RST;
        end else begin
            st_ff <= nxt_st;
        end
    end

    // ==========================================================
    // Outputs
    assign OSC_DRIVE_OUTPUT = st_ff.int_com;
    assign PHASE_ALIGN_O = 1'b0; // Open drain, only pulls low
    assign PHASE_ALIGN_OE = st_ff.align_oe;

    // Cascade taps
    assign CASCADE_OUT_STATIC = shift_q[NSEG-1];
    assign CASCADE_OUT_DYNAMIC = shift_q[NSTG-1];

    // Commons and segments
    assign COMMON_PHASE_OUTPUT = st_ff.common_phase_output;
    assign LCD_COMMON_FIRST = st_ff.com_first;
    assign LCD_COMMON_FIRST_MID = st_ff.first_mid;
    assign LCD_COMMON_SECOND = st_ff.com_second;
    assign LCD_COMMON_SECOND_MID = st_ff.second_mid;
    assign SEGMENT_OUTPUTS = st_ff.seg;

    // Bus handshakes
    assign AWREADY = ~st_ff.aw_got & ~st_ff.bvalid;
    assign WREADY = ~st_ff.w_got & ~st_ff.bvalid;
    assign BVALID = st_ff.bvalid;
    assign BRESP = st_ff.bresp;
    assign ARREADY = ~st_ff.rvalid;
    assign RVALID = st_ff.rvalid;
    assign RDATA = st_ff.rdata;
    assign RRESP = st_ff.rresp;
endmodule // seglcd_driver
`default_nettype wire

// File: seglcd_monitor.sv
// Port-level concurrent checks of the serial segment LCD driver
`timescale 1ns/100ps
`default_nettype none
module seglcd_monitor #(
    parameter int COM_HALF_CYCLES = seglcd_pkg::COM_HALF_CYC,
    parameter logic BLANK_ACTIVE_HIGH = seglcd_pkg::BLANK_ACTIVE_HIGH
) (
    input wire logic CLK, // System clock
    input wire logic SRST, // Synchronous reset
    input wire logic SHIFT_CLK, // Shift clock pin
    input wire logic BLANK_IN, // Blanking pin
    input wire logic ALL_ON_TEST_INPUT, // All-on pin
    input wire logic DYNAMIC_MODE_SELECT, // Mode pin
    input wire logic COMMON_SOURCE_SELECT, // Common source pin
    input wire logic OSC_COMMON_INPUT, // External common pin
    input wire logic OSC_DRIVE_OUTPUT, // Built-in generator
    input wire logic PHASE_ALIGN_O, // Line drive value
    input wire logic PHASE_ALIGN_OE, // Line drive enable
    input wire logic CASCADE_OUT_STATIC, // Stage 80
    input wire logic COMMON_PHASE_OUTPUT, // Common in use
    input wire logic LCD_COMMON_FIRST, // First common
    input wire logic LCD_COMMON_FIRST_MID, // First common idle bias
    input wire logic LCD_COMMON_SECOND, // Second common
    input wire logic LCD_COMMON_SECOND_MID, // Second common idle bias
    input wire logic [seglcd_pkg::NUM_SEG-1:0] SEGMENT_OUTPUTS // Segments
);
    logic osc_q_ff;
    logic seen_ff;
    int cnt_ff;
    wire logic blank_on = (BLANK_IN == BLANK_ACTIVE_HIGH);
    default clocking cb @(posedge CLK); endclocking
    default disable iff (SRST);
    // ==========================================
    // Cycles since the generator output last moved
    always_ff @(posedge CLK) begin
        if (SRST) begin
            osc_q_ff <= 1'h0;
            seen_ff <= 1'h0;
            cnt_ff <= 32'h0;
        end else begin
            osc_q_ff <= OSC_DRIVE_OUTPUT;
            seen_ff <= seen_ff | (OSC_DRIVE_OUTPUT != osc_q_ff);
            cnt_ff <= (OSC_DRIVE_OUTPUT != osc_q_ff) ? 32'h0 : cnt_ff + 32'h1;
        end
    end
    // ==========================================
    // Assertions
    a_test_on: assert property ((!SRST && ALL_ON_TEST_INPUT)[*5]
        |-> SEGMENT_OUTPUTS == {80{~COMMON_PHASE_OUTPUT}}) else $error("test not all on");
    a_blank_off: assert property ((!SRST && blank_on && !ALL_ON_TEST_INPUT)[*5]
        |-> SEGMENT_OUTPUTS == {80{COMMON_PHASE_OUTPUT}}) else $error("blank not all off");
    a_static_com: assert property ((!SRST && !DYNAMIC_MODE_SELECT)[*5]
        |-> LCD_COMMON_FIRST == COMMON_PHASE_OUTPUT && LCD_COMMON_SECOND == COMMON_PHASE_OUTPUT
        && !LCD_COMMON_FIRST_MID && !LCD_COMMON_SECOND_MID) else $error("static commons wrong");
    a_mid_excl: assert property (!(LCD_COMMON_FIRST_MID && LCD_COMMON_SECOND_MID))
        else $error("both commons idle");
    a_align_drive: assert property (PHASE_ALIGN_OE
        |-> LCD_COMMON_FIRST_MID && !PHASE_ALIGN_O) else $error("line pulled outside phase");
    a_ext_common: assert property ((!SRST && COMMON_SOURCE_SELECT)[*5]
        |-> COMMON_PHASE_OUTPUT == $past(OSC_COMMON_INPUT, 3)) else $error("common not followed");
    a_casc_timing: assert property ($changed(CASCADE_OUT_STATIC)
        |-> $past(SHIFT_CLK, 3) && !$past(SHIFT_CLK, 4)) else $error("cascade moved alone");
    a_osc_half: assert property (seen_ff && OSC_DRIVE_OUTPUT != osc_q_ff
        |-> cnt_ff == COM_HALF_CYCLES - 1) else $error("generator half period wrong");
    a_osc_alive: assert property (cnt_ff <= COM_HALF_CYCLES + 1)
        else $error("generator stuck");
    a_int_common: assert property ((!SRST && !COMMON_SOURCE_SELECT)[*5]
        |-> COMMON_PHASE_OUTPUT == $past(OSC_DRIVE_OUTPUT)) else $error("common not built-in");
endmodule // seglcd_monitor
bind seglcd_driver seglcd_monitor #(.COM_HALF_CYCLES(COM_HALF_CYCLES),
    .BLANK_ACTIVE_HIGH(BLANK_ACTIVE_HIGH)) mon_u (.CLK, .SRST, .SHIFT_CLK, .BLANK_IN,
    .ALL_ON_TEST_INPUT, .DYNAMIC_MODE_SELECT, .COMMON_SOURCE_SELECT, .OSC_COMMON_INPUT,
    .OSC_DRIVE_OUTPUT, .PHASE_ALIGN_O, .PHASE_ALIGN_OE, .CASCADE_OUT_STATIC,
    .COMMON_PHASE_OUTPUT, .LCD_COMMON_FIRST, .LCD_COMMON_FIRST_MID, .LCD_COMMON_SECOND,
    .LCD_COMMON_SECOND_MID, .SEGMENT_OUTPUTS);
`default_nettype wire

// File: seglcd_pkg.sv
// Package: constants and carrier types of the serial segment LCD driver
`default_nettype none
package seglcd_pkg;
    // Display geometry
    localparam int NUM_SEG = 80;
    localparam int NUM_STAGE = 160;
    // Timing: clock period and built-in common period
    localparam int CLK_PERIOD_NS = 50;
    localparam int COM_PERIOD_US = 10000;
    localparam int COM_HALF_CYC = (COM_PERIOD_US * 1000) / (2 * CLK_PERIOD_NS);
    // Blanking input level of the default variant
    localparam logic BLANK_ACTIVE_HIGH = 1'h0;
    // Register map, byte addresses
    localparam int ADDR_W = 8;
    localparam logic [7:0] REG_CTRL = 8'h00;
    localparam logic [7:0] REG_STATUS = 8'h04;
    localparam logic [7:0] REG_LATCH0 = 8'h10;
    localparam int LATCH_WORDS = 5;
    localparam int WORD_W = 32;
    // Control fields and reset value
    localparam int CTRL_SOFT_BLANK = 0;
    localparam logic SOFT_BLANK_RST = 1'h0;
    // Status fields
    localparam int ST_DYN = 0;
    localparam int ST_CSEL = 1;
    localparam int ST_COM = 2;
    localparam int ST_PHASE = 3;
    localparam int ST_ALIGN = 4;
    localparam int ST_BLANK = 5;
    localparam int ST_TEST = 6;
    localparam int ST_LOAD = 7;
    // Bus responses
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    // Which common holds the select phase in dynamic mode
    typedef enum logic {
        PH_FIRST = 1'b0,
        PH_SECOND = 1'b1
    } phase_type;
    // Pin inputs that cross into the clock domain together
    typedef struct packed {
        logic data;
        logic shclk;
        logic load;
        logic blank;
        logic test;
        logic dyn;
        logic csel;
        logic osc;
        logic align;
    } pin_type;
endpackage
`default_nettype wire

// File: testbench.sv
// Self-checking bench of the serial segment LCD driver
`timescale 1ns/100ps
`default_nettype none
`define CHK(nm, e, g) begin n_tests++; if ((g) !== (e)) begin errors++; \
    $display("wrong value %s expected %h seen %h", nm, e, g); end end
module testbench;
    typedef struct {int k; logic [79:0] e; string nm;} note_type;
    logic CLK = 1'h0;
    logic SRST = 1'h1;
    logic SERIAL_DATA_IN, SHIFT_CLK, LOAD_STROBE, OSC_DRIVE_OUTPUT, COMMON_PHASE_OUTPUT;
    logic BLANK_IN = 1'h1, ALL_ON_TEST_INPUT = 1'h0, DYNAMIC_MODE_SELECT = 1'h0;
    logic COMMON_SOURCE_SELECT = 1'h1, OSC_COMMON_INPUT = 1'h0;
    logic PHASE_ALIGN_I, PHASE_ALIGN_O, PHASE_ALIGN_OE, CASCADE_OUT_STATIC, CASCADE_OUT_DYNAMIC;
    logic LCD_COMMON_FIRST, LCD_COMMON_FIRST_MID, LCD_COMMON_SECOND, LCD_COMMON_SECOND_MID;
    logic [79:0] SEGMENT_OUTPUTS;
    logic [7:0] AWADDR = 8'h00, ARADDR = 8'h00;
    logic [31:0] WDATA = 32'h0, RDATA, rdt;
    logic [3:0] WSTRB = 4'hF;
    logic AWVALID = 1'h0, WVALID = 1'h0, BREADY = 1'h0, ARVALID = 1'h0, RREADY = 1'h0;
    logic AWREADY, WREADY, BVALID, ARREADY, RVALID;
    logic [1:0] BRESP, RRESP, rsp;
    logic gnd_line = 1'h1, peer_low = 1'h0;
    logic [159:0] d1, d2, d3;
    int errors = 0, n_tests = 0;
    note_type notes[$];
    note_type nt;
    // Shared pulled-up line: grounded, held by a peer, or pulled by the device
    assign PHASE_ALIGN_I = !(gnd_line || peer_low || (PHASE_ALIGN_OE && !PHASE_ALIGN_O));
    always #25 CLK = ~CLK;
    seglcd_driver #(.COM_HALF_CYCLES(20)) dut_u (.CLK, .SRST, .SERIAL_DATA_IN, .SHIFT_CLK,
        .LOAD_STROBE, .BLANK_IN, .ALL_ON_TEST_INPUT, .DYNAMIC_MODE_SELECT, .COMMON_SOURCE_SELECT,
        .OSC_COMMON_INPUT, .OSC_DRIVE_OUTPUT, .PHASE_ALIGN_I, .PHASE_ALIGN_O, .PHASE_ALIGN_OE,
        .CASCADE_OUT_STATIC, .CASCADE_OUT_DYNAMIC, .COMMON_PHASE_OUTPUT, .LCD_COMMON_FIRST,
        .LCD_COMMON_FIRST_MID, .LCD_COMMON_SECOND, .LCD_COMMON_SECOND_MID, .SEGMENT_OUTPUTS,
        .AWADDR, .AWVALID, .AWREADY, .WDATA, .WSTRB, .WVALID, .WREADY, .BRESP, .BVALID, .BREADY,
        .ARADDR, .ARVALID, .ARREADY, .RDATA, .RRESP, .RVALID, .RREADY);
    host_link host_u (.clk(CLK), .data_o(SERIAL_DATA_IN), .shclk_o(SHIFT_CLK), .load_o(LOAD_STROBE));
    // ==========================================
    // Tasks
    task automatic want(input int k, input logic [79:0] e, input string nm);
        notes.push_back('{k, e, nm});
    endtask
    task automatic waitc(input int n);
        repeat (n) @(posedge CLK);
    endtask
    function automatic logic [159:0] rnd();
        return {$urandom, $urandom, $urandom, $urandom, $urandom};
    endfunction
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge CLK);
        AWADDR <= a;
        WDATA <= d;
        AWVALID <= 1'h1;
        WVALID <= 1'h1;
        BREADY <= 1'h1;
        do begin
            @(posedge CLK);
            if (AWREADY) AWVALID <= 1'h0;
            if (WREADY) WVALID <= 1'h0;
        end while (!BVALID);
        rsp = BRESP;
        rdt = 32'h0;
        BREADY <= 1'h0;
    endtask
    task automatic rd(input logic [7:0] a);
        @(posedge CLK);
        ARADDR <= a;
        ARVALID <= 1'h1;
        RREADY <= 1'h1;
        do begin
            @(posedge CLK);
            if (ARREADY) ARVALID <= 1'h0;
        end while (!RVALID);
        rsp = RRESP;
        rdt = RDATA;
        RREADY <= 1'h0;
    endtask
    task automatic end_of_test;
        if (errors == 0 && n_tests > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask
    // Takes each pending note and compares it with the outputs it names
    always @(negedge CLK) begin
        while (notes.size() > 0) begin
            nt = notes.pop_front();
            case (nt.k)
                0: `CHK(nt.nm, nt.e, SEGMENT_OUTPUTS)
                1: `CHK(nt.nm, nt.e, {78'h0, CASCADE_OUT_STATIC, CASCADE_OUT_DYNAMIC})
                default: `CHK(nt.nm, nt.e, {46'h0, rsp, rdt})
            endcase
        end
    end
    // Watchdog
    initial begin
        repeat (20000) @(posedge CLK);
        errors++;
        end_of_test;
    end
    // ==========================================
    // Main sequence
    initial begin
        void'($urandom(59885));
        d1 = rnd();
        d2 = rnd();
        d3 = rnd();
        repeat (12) @(posedge CLK);
        SRST <= 1'h0;
        waitc(3);
        // Static expander: data straight through, then inverted
        host_u.send(d1, 80, 1'h1);
        want(0, d1[79:0], "seg");
        want(1, {d1[79], 1'h0}, "cascade");
        OSC_COMMON_INPUT <= 1'h1;
        waitc(6);
        want(0, ~d1[79:0], "seg inverted");
        OSC_COMMON_INPUT <= 1'h0;
        // Shifting with load low leaves the display alone
        host_u.send(d2, 80, 1'h0);
        want(0, d1[79:0], "seg held");
        want(1, {d2[79], d1[79]}, "cascade");
        host_u.send(d2, 0, 1'h1);
        want(0, d2[79:0], "seg loaded");
        // Blanking and the all-on test
        BLANK_IN <= 1'h0;
        waitc(6);
        want(0, 80'h0, "blank");
        ALL_ON_TEST_INPUT <= 1'h1;
        waitc(6);
        want(0, ~80'h0, "test");
        ALL_ON_TEST_INPUT <= 1'h0;
        waitc(6);
        want(0, 80'h0, "blank again");
        BLANK_IN <= 1'h1;
        waitc(6);
        want(0, d2[79:0], "restored");
        // Register bus: soft blank, status, latch word, unmapped place
        wr(seglcd_pkg::REG_CTRL, 32'h1);
        want(2, {seglcd_pkg::RESP_OKAY, 32'h0}, "ctrl write");
        waitc(6);
        want(0, 80'h0, "soft blank");
        rd(seglcd_pkg::REG_STATUS);
        want(2, {seglcd_pkg::RESP_OKAY, 32'h22}, "status");
        rd(seglcd_pkg::REG_LATCH0 + 8'h04);
        want(2, {seglcd_pkg::RESP_OKAY, d2[63:32]}, "latch word");
        rd(8'hFC);
        want(2, {seglcd_pkg::RESP_SLVERR, 32'h0}, "unmapped read");
        wr(8'hFC, 32'hFFFFFFFF);
        want(2, {seglcd_pkg::RESP_SLVERR, 32'h0}, "unmapped write");
        wr(seglcd_pkg::REG_CTRL, 32'h0);
        waitc(6);
        want(0, d2[79:0], "soft unblank");
        // Half duty: master common drives this device from outside
        gnd_line <= 1'h0;
        DYNAMIC_MODE_SELECT <= 1'h1;
        host_u.send(d3, 160, 1'h1);
        want(1, {d3[79], d3[159]}, "cascade dynamic");
        OSC_COMMON_INPUT <= 1'h1;
        waitc(8);
        want(0, ~d3[79:0], "first half");
        OSC_COMMON_INPUT <= 1'h0;
        waitc(8);
        want(0, d3[159:80], "second half");
        OSC_COMMON_INPUT <= 1'h1;
        waitc(8);
        peer_low <= 1'h1;
        waitc(4);
        OSC_COMMON_INPUT <= 1'h0;
        waitc(8);
        want(0, d3[79:0], "held by peer");
        peer_low <= 1'h0;
        // Built-in common generator in static mode
        COMMON_SOURCE_SELECT <= 1'h0;
        DYNAMIC_MODE_SELECT <= 1'h0;
        gnd_line <= 1'h1;
        waitc(120);
        end_of_test;
    end
endmodule // testbench
`default_nettype wire
